// >>> ecpcm_pkg.sv
// Purpose: shared constants for the echo canceller pcm ports
// Assumes: 32-bit ahb-lite slave, whole-word access only
// Notes: offsets are byte addresses, compared on haddr[7:0]
package ecpcm_pkg;
  // ---------------------------------------------------------
  // register map
  // ---------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_P1_TX = 8'h08;
  localparam logic [7:0] ADDR_P1_RX = 8'h0C;
  localparam logic [7:0] ADDR_P2_TX = 8'h10;
  localparam logic [7:0] ADDR_P2_RX = 8'h14;
  // control fields: bits 1:0 per port linear in strobed mode, bit 2 filter off
  localparam int CTRL_LIN = 0;
  localparam int CTRL_HPF_OFF = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // status fields
  localparam int ST_STROBED = 0;
  localparam int ST_RDY = 1;
  localparam int ST_OVR = 3;
  localparam int ST_FMT = 5;
  localparam int ST_LAW = 6;
  // ---------------------------------------------------------
  // framing
  // ---------------------------------------------------------
  localparam logic [3:0] LOW_HOLD_CLKS = 4'h8;
  localparam logic [9:0] SLOT2_START = 10'h010;
  localparam logic [9:0] BYTE_BITS = 10'h008;
  localparam logic [9:0] WORD_BITS = 10'h010;
  localparam logic [9:0] CNT_MAX = 10'h3FF;
  typedef enum logic [1:0] {
    SLOT_TS0 = 2'b00,
    SLOT_TS2 = 2'b01,
    SLOT_TS2_BYP = 2'b10,
    SLOT_LIN = 2'b11
  } ecpcm_slot_t;
  // ---------------------------------------------------------
  // companding
  // ---------------------------------------------------------
  localparam logic [15:0] MU_BIAS = 16'h0021;
  localparam logic [15:0] MU_CLIP = 16'h1FFF;
  localparam logic [15:0] A_CLIP = 16'h0FFF;
  localparam logic [7:0] XOR_MU = 8'h7F;
  localparam logic [7:0] XOR_A = 8'h55;
  localparam logic [7:0] QUIET_SM = 8'h80;
  localparam logic [7:0] QUIET_MU = 8'hFF;
  localparam logic [7:0] QUIET_A = 8'hD5;
  localparam int DC_SHIFT = 8;
endpackage

// >>> ecpcm_ports.sv
// Purpose: pcm serial ports of a speakerphone echo canceller
// Assumes: bit clock and strobes from the codec or backplane
// Notes: sample words reach software over ahb-lite
`timescale 1ns/1ps
module ecpcm_ports
  import ecpcm_pkg::*;
(
  // ahb-lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // power and code straps
  input wire logic power_down_n,
  input wire logic format_strap,
  input wire logic law_strap,
  // pcm link
  input wire logic tdm_bus_clock,
  input wire logic frame_pulse_n,
  input wire logic port1_enable_strobe,
  input wire logic port2_enable_strobe,
  input wire logic port1_mode_strap,
  input wire logic port2_mode_strap,
  input wire logic rin,
  input wire logic sin,
  output logic sout,
  output logic sout_oe,
  output logic rout,
  output logic rout_oe
);
  // ---------------------------------------------------------
  // codec functions
  // ---------------------------------------------------------
  // linear to 8-bit code, positive sign is 1
  function automatic logic [7:0] compress(input logic [15:0] x,
    input logic fmt, input logic law);
    logic [15:0] m;
    logic [2:0] seg;
    logic [3:0] man;
    logic [7:0] c;
    m = x[15] ? (~x + 16'h0001) : x;
    seg = 3'h0;
    if (!law)
    begin
      m = {2'h0, m[15:2]} + MU_BIAS;
      if (m > MU_CLIP)
        m = MU_CLIP;
      for (int i = 0; i < 8; i++)
        if (m[i+5])
          seg = 3'(i);
      m = (m >> seg) >> 1;
      man = m[3:0];
    end
    else
    begin
      m = {3'h0, m[15:3]};
      if (m > A_CLIP)
        m = A_CLIP;
      for (int i = 1; i < 8; i++)
        if (m[i+4])
          seg = 3'(i);
      m = (seg == 3'h0) ? (m >> 1) : (m >> seg);
      man = m[3:0];
    end
    c = {~x[15], seg, man};
    if (fmt)
      c = c ^ (law ? XOR_A : XOR_MU);
    return c;
  endfunction

  // 8-bit code to linear
  function automatic logic [15:0] expand(input logic [7:0] c,
    input logic fmt, input logic law);
    logic [7:0] d;
    logic [15:0] t;
    d = fmt ? (c ^ (law ? XOR_A : XOR_MU)) : c;
    if (!law)
      t = ((({11'h0, d[3:0], 1'b0} + MU_BIAS) << d[6:4]) - MU_BIAS) << 2;
    else if (d[6:4] == 3'h0)
      t = {11'h0, d[3:0], 1'b1} << 3;
    else
      t = (({11'h0, d[3:0], 1'b0} + MU_BIAS) << (d[6:4] - 3'h1)) << 3;
    return d[7] ? t : (~t + 16'h0001);
  endfunction

  // clamp a 17-bit difference to 16 bits
  function automatic logic [15:0] sat16(input logic [16:0] y);
    if (y[16] != y[15])
      return y[16] ? 16'h8000 : 16'h7FFF;
    return y[15:0];
  endfunction

  // ---------------------------------------------------------
  // reset and power down
  // ---------------------------------------------------------
  logic rst_n;
  logic lrst_n;
  logic [1:0] lrst_q;
  assign rst_n = hresetn & power_down_n;

  // link reset, released on the link clock
  always_ff @(posedge tdm_bus_clock or negedge rst_n)
  begin
    if (!rst_n)
      lrst_q <= 2'h0;
    else
      lrst_q <= {lrst_q[0], 1'b1};
  end
  assign lrst_n = lrst_q[1];

  // ---------------------------------------------------------
  // link domain: framing
  // ---------------------------------------------------------
  logic [3:0] fp_cnt_r;
  logic strobed_lk_r;
  logic [9:0] bit_cnt_r;
  logic [5:0] ls_in, ls1_r, ls2_r, ls3_r, lsv_r;
  logic [1:0] din, stb, win, byp, lin_lk, last, done_tgl_r;
  logic [1:0] out_r, oe_r;
  logic [3:0] idx_r [2];
  logic [15:0] rx_sh_r [2];
  logic [16:0] rx_word_r [2];
  logic [15:0] tx_sh_r [2];
  logic [2:0] ctrl_r;
  logic [15:0] tx_code_r [2];

  assign din = {sin, rin};
  assign stb = {port2_enable_strobe, port1_enable_strobe};
  assign ls_in = {ctrl_r[1:0], port2_mode_strap, port2_enable_strobe,
                  port1_mode_strap, port1_enable_strobe};

  // frame input low for a run of clocks means strobed mode
  always_ff @(posedge tdm_bus_clock or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      fp_cnt_r <= 4'h0;
      strobed_lk_r <= 1'b0;
    end
    else if (frame_pulse_n)
    begin
      fp_cnt_r <= 4'h0;
      strobed_lk_r <= 1'b0;
    end
    else if (fp_cnt_r == LOW_HOLD_CLKS - 4'h1)
      strobed_lk_r <= 1'b1;
    else
      fp_cnt_r <= fp_cnt_r + 4'h1;
  end

  // bit position within the frame, zeroed by the pulse
  always_ff @(posedge tdm_bus_clock or negedge lrst_n)
  begin
    if (!lrst_n)
      bit_cnt_r <= CNT_MAX;
    else if (!frame_pulse_n)
      bit_cnt_r <= 10'h000;
    else if (bit_cnt_r != CNT_MAX)
      bit_cnt_r <= bit_cnt_r + 10'h001;
  end

  // straps and control levels into the link domain
  always_ff @(posedge tdm_bus_clock or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      ls1_r <= 6'h00;
      ls2_r <= 6'h00;
      ls3_r <= 6'h00;
      lsv_r <= 6'h00;
    end
    else
    begin
      ls1_r <= ls_in;
      ls2_r <= ls1_r;
      ls3_r <= ls2_r;
      lsv_r <= (~(ls2_r ^ ls3_r) & ls3_r) | ((ls2_r ^ ls3_r) & lsv_r);
    end
  end

  sequence seq_fp_low8;
    !frame_pulse_n [*8];
  endsequence
  AST_STROBED_DETECT: assert property (@(posedge tdm_bus_clock)
    disable iff (!lrst_n) seq_fp_low8 |=> strobed_lk_r)
    else $error("strobed mode not entered after low frame input");
  AST_FRAMED_ON_HIGH: assert property (@(posedge tdm_bus_clock)
    disable iff (!lrst_n) frame_pulse_n |=> !strobed_lk_r)
    else $error("strobed mode kept with frame input high");

  // ---------------------------------------------------------
  // core domain: synchronisers
  // ---------------------------------------------------------
  logic [4:0] cs_in, cs1_r, cs2_r, cs3_r, csv_r;
  logic [1:0] ev, rdy_r, ovr_r;
  logic fmt_c, law_c;
  assign cs_in = {done_tgl_r, strobed_lk_r, law_strap, format_strap};
  assign fmt_c = csv_r[0];
  assign law_c = csv_r[1];

  // three stages, a change counts when stages two and three agree
  always_ff @(posedge hclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs1_r <= 5'h00;
      cs2_r <= 5'h00;
      cs3_r <= 5'h00;
      csv_r <= 5'h00;
    end
    else
    begin
      cs1_r <= cs_in;
      cs2_r <= cs1_r;
      cs3_r <= cs2_r;
      csv_r <= (~(cs2_r ^ cs3_r) & cs3_r) | ((cs2_r ^ cs3_r) & csv_r);
    end
  end

  // ---------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------
  logic taken, wr_pend_r;
  logic [7:0] waddr_r;
  logic [31:0] rd_mux;
  logic [15:0] tx_lin_r [2];
  logic [15:0] rx_lin_r [2];
  assign taken = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address phase capture
  always_ff @(posedge hclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_r <= 1'b0;
      waddr_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= taken & hwrite;
      if (taken)
        waddr_r <= haddr[7:0];
    end
  end

  // read decode, unmapped reads as zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (haddr[7:0] == ADDR_CTRL)
      rd_mux = {29'h0, ctrl_r};
    else if (haddr[7:0] == ADDR_STATUS)
      rd_mux = {25'h0, law_c, fmt_c, ovr_r, rdy_r, csv_r[2]};
    else if (haddr[7:0] == ADDR_P1_TX)
      rd_mux = {16'h0, tx_lin_r[0]};
    else if (haddr[7:0] == ADDR_P1_RX)
      rd_mux = {16'h0, rx_lin_r[0]};
    else if (haddr[7:0] == ADDR_P2_TX)
      rd_mux = {16'h0, tx_lin_r[1]};
    else if (haddr[7:0] == ADDR_P2_RX)
      rd_mux = {16'h0, rx_lin_r[1]};
  end

  // read data registered at the address phase
  always_ff @(posedge hclk or negedge rst_n)
  begin
    if (!rst_n)
      hrdata <= 32'h0000_0000;
    else if (taken & !hwrite)
      hrdata <= rd_mux;
  end

  // control register
  always_ff @(posedge hclk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_r <= CTRL_RESET;
    else if (wr_pend_r && waddr_r == ADDR_CTRL)
      ctrl_r <= hwdata[2:0];
  end

  AST_PD_OUTS_OFF: assert property (@(posedge hclk)
    disable iff (!hresetn) !power_down_n |-> !sout_oe && !rout_oe)
    else $error("pcm output driven during power down");

  // ---------------------------------------------------------
  // per port: link shifter and core sample path
  // ---------------------------------------------------------
  logic [15:0] dec [2];
  logic [16:0] hp_y [2];
  logic [23:0] acc_r [2];
  for (genvar p = 0; p < 2; p++)
  begin : g_port
    localparam logic [7:0] TXA = p ? ADDR_P2_TX : ADDR_P1_TX;
    ecpcm_slot_t mode;
    logic [9:0] start, wlen;
    logic clr_rdy, clr_ovr;
    assign mode = ecpcm_slot_t'(lsv_r[2*p+1 -: 2]);
    // slot choice from the straps, or width from control
    assign lin_lk[p] = strobed_lk_r ? lsv_r[4+p] : (mode == SLOT_LIN);
    assign start = (mode == SLOT_TS2 || mode == SLOT_TS2_BYP) ?
                   SLOT2_START : 10'h000;
    assign wlen = lin_lk[p] ? WORD_BITS : BYTE_BITS;
    assign win[p] = strobed_lk_r ? stb[p] :
                    (bit_cnt_r >= start && bit_cnt_r < start + wlen);
    assign byp[p] = !strobed_lk_r && mode == SLOT_TS2_BYP &&
                    bit_cnt_r < SLOT2_START;
    assign last[p] = win[p] && idx_r[p] == wlen[3:0] - 4'h1;

    // bit index inside the window
    always_ff @(posedge tdm_bus_clock or negedge lrst_n)
    begin
      if (!lrst_n)
        idx_r[p] <= 4'h0;
      else if (!win[p])
        idx_r[p] <= 4'h0;
      else
        idx_r[p] <= idx_r[p] + 4'h1;
    end

    // receive shifter, word handed over with a toggle
    always_ff @(posedge tdm_bus_clock or negedge lrst_n)
    begin
      if (!lrst_n)
      begin
        rx_sh_r[p] <= 16'h0000;
        rx_word_r[p] <= 17'h00000;
        done_tgl_r[p] <= 1'b0;
      end
      else
      begin
        if (win[p])
          rx_sh_r[p] <= {rx_sh_r[p][14:0], din[p]};
        if (last[p])
        begin
          rx_word_r[p] <= {lin_lk[p], rx_sh_r[p][14:0], din[p]};
          done_tgl_r[p] <= ~done_tgl_r[p];
        end
      end
    end

    // transmit shifter and pin drive
    always_ff @(posedge tdm_bus_clock or negedge lrst_n)
    begin
      if (!lrst_n)
      begin
        tx_sh_r[p] <= 16'h0000;
        out_r[p] <= 1'b0;
        oe_r[p] <= 1'b0;
      end
      else
      begin
        if (!win[p])
          tx_sh_r[p] <= lin_lk[p] ? tx_code_r[p] :
                        {tx_code_r[p][7:0], 8'h00};
        else
          tx_sh_r[p] <= {tx_sh_r[p][14:0], 1'b0};
        out_r[p] <= win[p] ? tx_sh_r[p][15] : din[1-p];
        oe_r[p] <= win[p] | byp[p];
      end
    end

    AST_SLOT_POS: assert property (@(posedge tdm_bus_clock)
      disable iff (!lrst_n) !strobed_lk_r && mode == SLOT_TS2 && win[p]
      |-> bit_cnt_r >= 10'h010 && bit_cnt_r < 10'h018)
      else $error("framed window outside timeslot 2");
    AST_OE_FOLLOWS_WIN: assert property (@(posedge tdm_bus_clock)
      disable iff (!lrst_n) win[p] |=> oe_r[p])
      else $error("output not enabled during its window");
    AST_LAST_TOGGLES: assert property (@(posedge tdm_bus_clock)
      disable iff (!lrst_n) last[p] |=> $changed(done_tgl_r[p]))
      else $error("completed word not handed over");

    // core: decode, offset null, encode next transmit word
    assign ev[p] = ~(cs2_r[3+p] ^ cs3_r[3+p]) & (cs3_r[3+p] ^ csv_r[3+p]);
    assign dec[p] = rx_word_r[p][16] ? rx_word_r[p][15:0] :
                    expand(rx_word_r[p][7:0], fmt_c, law_c);
    assign hp_y[p] = {dec[p][15], dec[p]} -
                     {acc_r[p][23], acc_r[p][DC_SHIFT+15:DC_SHIFT]};

    always_ff @(posedge hclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        acc_r[p] <= 24'h000000;
        rx_lin_r[p] <= 16'h0000;
        tx_code_r[p] <= 16'h0000;
      end
      else if (ev[p])
      begin
        acc_r[p] <= acc_r[p] + {{7{hp_y[p][16]}}, hp_y[p]};
        rx_lin_r[p] <= ctrl_r[CTRL_HPF_OFF] ? dec[p] : sat16(hp_y[p]);
        tx_code_r[p] <= rx_word_r[p][16] ? tx_lin_r[p] :
                        {8'h00, compress(tx_lin_r[p], fmt_c, law_c)};
      end
    end

    // transmit sample written by software
    always_ff @(posedge hclk or negedge rst_n)
    begin
      if (!rst_n)
        tx_lin_r[p] <= 16'h0000;
      else if (wr_pend_r && waddr_r == TXA)
        tx_lin_r[p] <= hwdata[15:0];
    end

    // sticky ready and overrun, a new sample wins over clear
    assign clr_rdy = wr_pend_r && waddr_r == ADDR_STATUS &&
                     hwdata[ST_RDY+p];
    assign clr_ovr = wr_pend_r && waddr_r == ADDR_STATUS &&
                     hwdata[ST_OVR+p];
    always_ff @(posedge hclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        rdy_r[p] <= 1'b0;
        ovr_r[p] <= 1'b0;
      end
      else
      begin
        rdy_r[p] <= ev[p] | (rdy_r[p] & ~clr_rdy);
        ovr_r[p] <= (ev[p] & rdy_r[p]) | (ovr_r[p] & ~clr_ovr);
      end
    end

    AST_CROSS_LAT: assert property (@(posedge hclk)
      disable iff (!rst_n) $changed(done_tgl_r[p]) |-> ##[2:4] ev[p])
      else $error("link word not seen in core in time");
    AST_RDY_SET: assert property (@(posedge hclk)
      disable iff (!rst_n) ev[p] |=> rdy_r[p])
      else $error("ready flag not set by new sample");
    AST_SM_QUIET: assert property (@(posedge hclk)
      disable iff (!rst_n) ev[p] && !rx_word_r[p][16] && !fmt_c &&
      tx_lin_r[p] == 16'h0000 |=> tx_code_r[p] == {8'h00, QUIET_SM})
      else $error("sign-magnitude zero code wrong");
    AST_G711_QUIET: assert property (@(posedge hclk)
      disable iff (!rst_n) ev[p] && !rx_word_r[p][16] && fmt_c &&
      tx_lin_r[p] == 16'h0000 |=> tx_code_r[p] ==
      {8'h00, ($past(law_c) ? QUIET_A : QUIET_MU)})
      else $error("g711 zero code wrong");
    AST_HPF_BYPASS: assert property (@(posedge hclk)
      disable iff (!rst_n) ev[p] && ctrl_r[CTRL_HPF_OFF]
      |=> rx_lin_r[p] == $past(dec[p]))
      else $error("filter bypass altered sample");
    AST_HPF_DC_NULL: assert property (@(posedge hclk)
      disable iff (!rst_n) ev[p] && !ctrl_r[CTRL_HPF_OFF] &&
      dec[p] == acc_r[p][DC_SHIFT+15:DC_SHIFT] |=> rx_lin_r[p] == 16'h0000)
      else $error("dc level not nulled");
  end

  // pins
  assign sout = out_r[0];
  assign sout_oe = oe_r[0];
  assign rout = out_r[1];
  assign rout_oe = oe_r[1];
endmodule // ecpcm_ports

// >>> ecpcm_codec_model.sv
// Purpose: codec model on the far side of the strobed pcm link
// Assumes: strobed mode, frame input held at ground except in the framed timeslot 0 task
// Notes: captures both serial outputs during each window
`timescale 1ns/1ps
module ecpcm_codec_model
#(
  parameter int FRAME_CLKS = 8333
)
(
  // link clock and framing
  output logic tdm_bus_clock,
  output logic frame_pulse_n,
  output logic port1_enable_strobe,
  output logic port2_enable_strobe,
  // serial data
  output logic rin,
  output logic sin,
  input wire logic sout,
  input wire logic sout_oe,
  input wire logic rout,
  input wire logic rout_oe
);
  logic [15:0] cap1;
  logic [15:0] cap2;
  // ---------------------------------------------------------
  // link clock and idle levels
  // ---------------------------------------------------------
  // bit clock runs free, 15 ns period, unrelated to hclk
  initial
  begin
    tdm_bus_clock = 1'b0;
    forever #7.5 tdm_bus_clock = ~tdm_bus_clock;
  end
  // frame input grounded, strobes low between windows
  initial
  begin
    frame_pulse_n = 1'b0;
    port1_enable_strobe = 1'b0;
    port2_enable_strobe = 1'b0;
    rin = 1'b0;
    sin = 1'b0;
  end
  // ---------------------------------------------------------
  // one window on both ports, msb first, then rest of frame
  // ---------------------------------------------------------
  task automatic xfer(input int w, input logic [15:0] d1,
    input logic [15:0] d2);
    int k;
    cap1 = 16'h0000;
    cap2 = 16'h0000;
    @(negedge tdm_bus_clock);
    port1_enable_strobe = 1'b1;
    port2_enable_strobe = 1'b1;
    rin = d1[w-1];
    sin = d2[w-1];
    for (k = w - 1; k >= 0; k--)
    begin
      @(negedge tdm_bus_clock);
      cap1[k] = sout_oe ? sout : 1'bx;
      cap2[k] = rout_oe ? rout : 1'bx;
      if (k > 0)
      begin
        rin = d1[k-1];
        sin = d2[k-1];
      end
    end
    // released lines show the inverse of the last bit
    port1_enable_strobe = 1'b0;
    port2_enable_strobe = 1'b0;
    rin = ~rin;
    sin = ~sin;
    repeat (FRAME_CLKS - w) @(posedge tdm_bus_clock);
  endtask
  // ---------------------------------------------------------
  // one framed timeslot 0 byte on both ports, then strobed again
  // ---------------------------------------------------------
  // long high run first so the leftover bit count passes slot 0
  task automatic tdm(input logic [7:0] d1, input logic [7:0] d2);
    int k;
    cap1 = 16'h0000;
    cap2 = 16'h0000;
    @(negedge tdm_bus_clock);
    frame_pulse_n = 1'b1;
    repeat (12) @(negedge tdm_bus_clock);
    frame_pulse_n = 1'b0;
    @(negedge tdm_bus_clock);
    frame_pulse_n = 1'b1;
    rin = d1[7];
    sin = d2[7];
    for (k = 7; k >= 0; k--)
    begin
      @(negedge tdm_bus_clock);
      cap1[k] = sout_oe ? sout : 1'bx;
      cap2[k] = rout_oe ? rout : 1'bx;
      if (k > 0)
      begin
        rin = d1[k-1];
        sin = d2[k-1];
      end
    end
    // back to a grounded frame input, long enough for strobed mode
    rin = ~rin;
    sin = ~sin;
    frame_pulse_n = 1'b0;
    repeat (40) @(posedge tdm_bus_clock);
  endtask
endmodule // ecpcm_codec_model

// >>> echo_canceller_pcm_ports_tb_top.sv
// Purpose: self-checking bench for the pcm ports block
// Assumes: strobed link mode except the framed timeslot 0 check, ahb-lite master with idle gaps
// Notes: expected values worked out from straps and samples
`timescale 1ns/1ps
module echo_canceller_pcm_ports_tb_top;
  import ecpcm_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic power_down_n, format_strap, law_strap;
  logic tdm_bus_clock, frame_pulse_n, rin, sin;
  logic port1_enable_strobe, port2_enable_strobe;
  logic sout, sout_oe, rout, rout_oe;
  logic [7:0] qc [4];
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  // ---------------------------------------------------------
  // clock, bus ready and timeout
  // ---------------------------------------------------------
  // core clock 50 ns
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  assign hready = hreadyout;
  // hang guard
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      miscompares++;
      finish_test;
    end
  end
  // ---------------------------------------------------------
  // instances
  // ---------------------------------------------------------
  ecpcm_ports i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .power_down_n(power_down_n),
    .format_strap(format_strap), .law_strap(law_strap),
    .tdm_bus_clock(tdm_bus_clock), .frame_pulse_n(frame_pulse_n),
    .port1_enable_strobe(port1_enable_strobe),
    .port2_enable_strobe(port2_enable_strobe),
    .port1_mode_strap(1'b0), .port2_mode_strap(1'b0), .rin(rin),
    .sin(sin), .sout(sout), .sout_oe(sout_oe), .rout(rout),
    .rout_oe(rout_oe));
  ecpcm_codec_model i_codec (.tdm_bus_clock(tdm_bus_clock),
    .frame_pulse_n(frame_pulse_n),
    .port1_enable_strobe(port1_enable_strobe),
    .port2_enable_strobe(port2_enable_strobe), .rin(rin), .sin(sin),
    .sout(sout), .sout_oe(sout_oe), .rout(rout), .rout_oe(rout_oe));
  // ---------------------------------------------------------
  // tasks
  // ---------------------------------------------------------
  task automatic finish_test;
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // single ahb-lite transfer, held until hready
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
    input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  function automatic logic [31:0] st(input logic [1:0] rdy,
    input logic [1:0] ovr);
    return {25'h0, law_strap, format_strap, ovr, rdy, 1'b1};
  endfunction
  // one frame on both ports, optional status check and clear
  task automatic frame(input int w, input logic [15:0] d1,
    input logic [15:0] d2, input logic clr);
    repeat (4) @(posedge hclk);
    i_codec.xfer(w, d1, d2);
    if (clr)
    begin
      rchk("status", ADDR_STATUS, st(2'b11, 2'b00));
      wr(ADDR_STATUS, 32'h1E);
    end
  endtask
  // ---------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------
  initial
  begin
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hresetn = 1'b0;
    power_down_n = 1'b1;
    format_strap = 1'b0;
    law_strap = 1'b0;
    qc = '{QUIET_SM, QUIET_SM, QUIET_MU, QUIET_A};
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, unmapped and read-only places
    rchk("ctrl", ADDR_CTRL, {29'h0, CTRL_RESET});
    rchk("p1_tx", ADDR_P1_TX, 32'h0);
    wr(8'h40, 32'hFFFFFFFF);
    rchk("unmapped", 8'h40, 32'h0);
    repeat (20) @(posedge hclk);
    wr(ADDR_STATUS, 32'h61);
    rchk("status", ADDR_STATUS, st(2'b00, 2'b00));
    // zero sample coded under every strap pair
    for (int i = 0; i < 4; i++)
    begin
      format_strap <= i[1];
      law_strap <= i[0];
      frame(8, 16'h0000, 16'h0000, 1'b1);
      frame(8, 16'h0000, 16'h0000, 1'b1);
      chk("sout code", {24'h0, qc[i]}, {16'h0, i_codec.cap1});
      chk("rout code", {24'h0, qc[i]}, {16'h0, i_codec.cap2});
    end
    format_strap <= 1'b0;
    law_strap <= 1'b0;
    // framed timeslot 0 bytes, quiet code sent back
    i_codec.tdm(8'h80, 8'h80);
    i_codec.tdm(8'h80, 8'h80);
    chk("ts0 sout", {24'h0, QUIET_SM}, {16'h0, i_codec.cap1});
    chk("ts0 rout", {24'h0, QUIET_SM}, {16'h0, i_codec.cap2});
    // power down clears registers and turns outputs off
    wr(ADDR_CTRL, 32'h3);
    power_down_n <= 1'b0;
    repeat (4) @(posedge hclk);
    chk("sout_oe", 32'h0, {31'h0, sout_oe});
    chk("rout_oe", 32'h0, {31'h0, rout_oe});
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    power_down_n <= 1'b1;
    repeat (20) @(posedge hclk);
    rchk("ctrl", ADDR_CTRL, 32'h0);
    // offset filter on a constant linear input
    wr(ADDR_CTRL, 32'h3);
    frame(16, 16'h4000, 16'h0000, 1'b1);
    rchk("p1_rx", ADDR_P1_RX, 32'h4000);
    frame(16, 16'h4000, 16'h0000, 1'b1);
    rchk("p1_rx", ADDR_P1_RX, 32'h3FC0);
    rchk("p2_rx", ADDR_P2_RX, 32'h0);
    // linear words both ways with the filter off
    wr(ADDR_CTRL, 32'h7);
    wr(ADDR_P1_TX, 32'hA5C3);
    wr(ADDR_P2_TX, 32'h5A3C);
    frame(16, 16'h1234, 16'h8765, 1'b1);
    rchk("p1_rx", ADDR_P1_RX, 32'h1234);
    rchk("p2_rx", ADDR_P2_RX, 32'h8765);
    frame(16, 16'h0001, 16'h8000, 1'b1);
    chk("sout word", 32'hA5C3, {16'h0, i_codec.cap1});
    chk("rout word", 32'h5A3C, {16'h0, i_codec.cap2});
    // second sample before clearing ready flags
    frame(16, 16'h0002, 16'h0003, 1'b0);
    frame(16, 16'h0004, 16'h0005, 1'b0);
    rchk("status", ADDR_STATUS, st(2'b11, 2'b11));
    wr(ADDR_STATUS, 32'h1E);
    rchk("status", ADDR_STATUS, st(2'b00, 2'b00));
    finish_test;
  end
endmodule // echo_canceller_pcm_ports_tb_top
